/* inc/imha_pkg.sv */
// Constants, codes and state type for the indirect multihost access block
package imha_pkg;
    // Command codes decoded by this block
    localparam logic [7:0] CMD_GLOBAL_MASK = 8'hE4;
    localparam logic [7:0] CMD_BASE_ADDR = 8'hE6;
    localparam logic [7:0] CMD_INDIRECT = 8'hC8;
    localparam logic [7:0] CMD_DATA_HOST0 = 8'hC9;
    localparam logic [7:0] CMD_DATA_HOST1 = 8'hCA;
    // The only standard commands that accept global-page writes
    localparam logic [7:0] CMD_OPERATION = 8'h01;
    localparam logic [7:0] CMD_ON_OFF_CFG = 8'h02;
    localparam logic [7:0] CMD_CLEAR_FAULTS = 8'h03;
    localparam logic [7:0] PAGE_GLOBAL = 8'hFF;

    // Indirect pointer locations with local meaning
    localparam logic [8:0] LOC_STATUS_HOST0 = 9'h02C;
    localparam logic [8:0] LOC_STATUS_HOST1 = 9'h02D;
    localparam logic [8:0] LOC_FAULT_LOG = 9'h0EE;

    // Poke enable and disable words, one pair per host
    localparam logic [15:0] POKE_EN_HOST0 = 16'h0BF6;
    localparam logic [15:0] POKE_DIS_HOST0 = 16'h01F6;
    localparam logic [15:0] POKE_EN_HOST1 = 16'h4BF6;
    localparam logic [15:0] POKE_DIS_HOST1 = 16'h41F6;

    // Indirect command word fields
    localparam int CP_HOST_BIT = 14;
    localparam int CP_PAGE_HI = 13;
    localparam int CP_PAGE_LO = 9;
    localparam int CP_PTR_HI = 8;
    localparam int CP_PTR_LO = 0;
    localparam int CP_PAGE_W = CP_PAGE_HI - CP_PAGE_LO + 1;
    localparam int CP_PTR_W = CP_PTR_HI - CP_PTR_LO + 1;

    // Status word bit positions
    localparam int STAT_POKE_FAIL_BIT = 1;
    localparam int STAT_PEEK_FAIL_BIT = 0;

    // Field widths and reset values
    localparam int MASK_W = 2;
    localparam int BASE_W = 7;
    localparam logic [MASK_W-1:0] MASK_RESET = 2'h3;
    localparam logic [BASE_W-1:0] BASE_RESET = 7'h5C;

    // Address offset by address-select pin pair {hi, lo}
    localparam logic [BASE_W-1:0] ADDR_OFFS_00 = 7'h00;
    localparam logic [BASE_W-1:0] ADDR_OFFS_01 = 7'h01;
    localparam logic [BASE_W-1:0] ADDR_OFFS_10 = 7'h04;
    localparam logic [BASE_W-1:0] ADDR_OFFS_11 = 7'h08;

    // Block buffer size in 16-bit words
    localparam int BLK_WORDS_DEF = 128;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_INT,
        ST_BUF,
        ST_DONE
    } imha_state_t;
endpackage

/* logic/imha_blk_ram.sv */
// Block read buffer: one write port, one registered read port
`timescale 1ns/1ps
module imha_blk_ram #(
    parameter int WORDS = 128,
    parameter int AW = 7
) (
    input wire logic sys_clk_in,
    input wire logic wr_en_in,
    input wire logic [AW-1:0] wr_addr_in,
    input wire logic [15:0] wr_data_in,
    input wire logic [AW-1:0] rd_addr_in,
    output logic [15:0] rd_data_out
);
    logic [15:0] mem_r [WORDS];
    logic [15:0] rd_data_r;

    // No reset on the array so it maps onto block memory
    always_ff @(posedge sys_clk_in)
    begin
        if (wr_en_in)
        begin
            mem_r[wr_addr_in] <= wr_data_in;
        end
        rd_data_r <= mem_r[rd_addr_in];
    end

    assign rd_data_out = rd_data_r;
endmodule // imha_blk_ram

/* logic/imha_top.sv */
// Command-level register logic for global mask, bus address and indirect hosts
//
// Summary of operation
// - Mask bit per channel enables global-page response; bits 7..2 read zero.
// - Bus address is base plus pin-selected offset 0..8; both pins high gives 8.
// - Base register keeps 7 bits; bit 7 reads zero.
// - Block data can be fetched by successive word reads of a data register.
// - Two extra hosts may read any location, each with its own page.
// - Two extra hosts may write any location except 0x2C, 0x2D and 0xEE, each with its own page.
// - Indirect traffic leaves standard command handling and standard page untouched.
// - Indirect command bit 15 reads as zero.
// - Indirect command bit 14 picks which host's pointer and page are stored.
// - Bits 13..9 hold the indirect page, latched per selected host.
// - Bits 8..0 hold the location pointer, latched per selected host.
// - Data register read returns content at that host's latched pointer and page.
// - Fault-log pointer streams whole block buffer; reads past end give zero.
// - Data register write stores at latched pointer only when pokes are enabled.
// - Word 0x0BF6 enables and 0x01F6 disables pokes for host 0.
// - Word 0x4BF6 enables and 0x41F6 disables pokes for host 1.
// - Status at 0x2C/0x2D flags failed poke and aborted block read.
// - Global page writes only for three commands, else fault and dropped; paged global-page reads fault; this block's own codes ignore the page.
`timescale 1ns/1ps
module imha_top #(
    parameter int BLK_WORDS = imha_pkg::BLK_WORDS_DEF,
    parameter int BLK_AW = $clog2(BLK_WORDS)
) (
    input wire logic sys_clk_in,
    input wire logic rst_in,
    input wire logic addr_select_hi_pin_in,
    input wire logic addr_select_lo_pin_in,
    output logic [6:0] bus_address_out,
    output logic [1:0] global_page_channel_mask_out,
    input wire logic cmd_valid_in,
    input wire logic cmd_write_in,
    input wire logic [7:0] cmd_code_in,
    input wire logic [7:0] cmd_page_in,
    input wire logic cmd_paged_in,
    input wire logic [15:0] cmd_wdata_in,
    output logic cmd_ready_out,
    output logic cmd_done_out,
    output logic [15:0] cmd_rdata_out,
    output logic comm_logic_fault_out,
    output logic int_req_out,
    output logic int_write_out,
    output logic [8:0] int_addr_out,
    output logic [7:0] int_page_out,
    output logic int_global_out,
    output logic [1:0] int_chan_mask_out,
    output logic [15:0] int_wdata_out,
    input wire logic int_ack_in,
    input wire logic int_byte_in,
    input wire logic [15:0] int_rdata_in,
    input wire logic blk_wr_in,
    input wire logic [BLK_AW-1:0] blk_waddr_in,
    input wire logic [15:0] blk_wdata_in,
    input wire logic fault_log_abort_in
);
    localparam logic [BLK_AW:0] BLK_END = (BLK_AW+1)'(BLK_WORDS);

    imha_pkg::imha_state_t state_r;
    imha_pkg::imha_state_t state_nxt;

    logic [1:0] asel_s1_r;
    logic [1:0] asel_s2_r;
    logic [imha_pkg::MASK_W-1:0] mask_r;
    logic [imha_pkg::BASE_W-1:0] base_r;
    logic [imha_pkg::BASE_W-1:0] addr_r;
    logic [14:0] cplus_r;
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic fault_r;
    logic int_write_r;
    logic [8:0] int_addr_r;
    logic [7:0] int_page_r;
    logic int_global_r;
    logic [1:0] int_mask_r;
    logic [15:0] int_wdata_r;
    logic past_end_r;

    logic [8:0] ptr_w [2];
    logic [4:0] page_w [2];
    logic [BLK_AW:0] idx_w [2];
    logic poke_en_w [2];
    logic poke_fail_w [2];
    logic peek_fail_w [2];
    logic [15:0] ram_q;

    // Command decode
    wire acc = (state_r == imha_pkg::ST_IDLE) && cmd_valid_in;
    wire wr = cmd_write_in;
    wire [15:0] wd = cmd_wdata_in;
    wire is_mask = cmd_code_in == imha_pkg::CMD_GLOBAL_MASK;
    wire is_base = cmd_code_in == imha_pkg::CMD_BASE_ADDR;
    wire is_cplus = cmd_code_in == imha_pkg::CMD_INDIRECT;
    wire is_data0 = cmd_code_in == imha_pkg::CMD_DATA_HOST0;
    wire is_data1 = cmd_code_in == imha_pkg::CMD_DATA_HOST1;
    wire is_data = is_data0 || is_data1;
    wire is_own = is_mask || is_base || is_cplus || is_data;
    wire hsel = is_data1;
    wire [8:0] sel_ptr = ptr_w[hsel];
    wire [4:0] sel_page = page_w[hsel];
    wire sel_poke_en = poke_en_w[hsel];
    wire [BLK_AW:0] sel_idx = idx_w[hsel];

    wire sel_stat0 = sel_ptr == imha_pkg::LOC_STATUS_HOST0;
    wire sel_stat1 = sel_ptr == imha_pkg::LOC_STATUS_HOST1;
    wire sel_stat = sel_stat0 || sel_stat1;
    wire sel_log = sel_ptr == imha_pkg::LOC_FAULT_LOG;
    wire sel_special = sel_stat || sel_log;

    wire cp_special = (wd == imha_pkg::POKE_EN_HOST0) || (wd == imha_pkg::POKE_DIS_HOST0)
        || (wd == imha_pkg::POKE_EN_HOST1) || (wd == imha_pkg::POKE_DIS_HOST1);
    wire cp_latch = acc && wr && is_cplus && !cp_special;
    wire cp_host = wd[imha_pkg::CP_HOST_BIT];

    // Status locations exist only behind the indirect path
    wire is_hidden = ({1'b0, cmd_code_in} == imha_pkg::LOC_STATUS_HOST0)
        || ({1'b0, cmd_code_in} == imha_pkg::LOC_STATUS_HOST1);
    wire is_global = cmd_page_in == imha_pkg::PAGE_GLOBAL;
    wire glob_ok = (cmd_code_in == imha_pkg::CMD_OPERATION)
        || (cmd_code_in == imha_pkg::CMD_ON_OFF_CFG)
        || (cmd_code_in == imha_pkg::CMD_CLEAR_FAULTS);
    wire glob_bad = is_global && (wr ? !glob_ok : cmd_paged_in);
    wire std_fault = !is_own && (is_hidden || glob_bad);
    wire fwd_std = acc && !is_own && !std_fault;
    wire fwd_ind = acc && is_data && !sel_special && (!wr || sel_poke_en);
    wire log_read = acc && is_data && !wr && sel_log;

    wire stat_host = sel_stat1;
    wire [15:0] stat_word = 16'((poke_fail_w[stat_host] ? 1 << imha_pkg::STAT_POKE_FAIL_BIT : 0)
        | (peek_fail_w[stat_host] ? 1 << imha_pkg::STAT_PEEK_FAIL_BIT : 0));

    wire [15:0] own_rdata =
        is_mask ? {14'h0000, mask_r} :
        is_base ? {9'h000, base_r} :
        is_cplus ? {1'b0, cplus_r} :
        (is_data && sel_stat) ? stat_word : 16'h0000;

    // Address-select pins are asynchronous
    always_ff @(posedge sys_clk_in)
    begin
        asel_s1_r <= {addr_select_hi_pin_in, addr_select_lo_pin_in};
        asel_s2_r <= asel_s1_r;
    end

    wire [imha_pkg::BASE_W-1:0] addr_offs =
        (asel_s2_r == 2'h3) ? imha_pkg::ADDR_OFFS_11 :
        (asel_s2_r == 2'h2) ? imha_pkg::ADDR_OFFS_10 :
        (asel_s2_r == 2'h1) ? imha_pkg::ADDR_OFFS_01 : imha_pkg::ADDR_OFFS_00;

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            mask_r <= imha_pkg::MASK_RESET;
            base_r <= imha_pkg::BASE_RESET;
            addr_r <= imha_pkg::BASE_RESET;
            cplus_r <= 15'h0000;
        end
        else
        begin
            addr_r <= base_r + addr_offs;
            if (acc && wr && is_mask)
            begin
                mask_r <= wd[imha_pkg::MASK_W-1:0];
            end
            if (acc && wr && is_base)
            begin
                base_r <= wd[imha_pkg::BASE_W-1:0];
            end
            if (acc && wr && is_cplus)
            begin
                cplus_r <= wd[14:0];
            end
        end
    end

    // Per-host context
    genvar h;
    generate
        for (h = 0; h < 2; h++)
        begin : g_host
            logic [8:0] ptr_r;
            logic [4:0] page_r;
            logic [BLK_AW:0] idx_r;
            logic poke_en_r;
            logic poke_fail_r;
            logic peek_fail_r;
            wire latch = cp_latch && (cp_host == 1'(h));
            wire en = acc && wr && is_cplus
                && (wd == (h == 0 ? imha_pkg::POKE_EN_HOST0 : imha_pkg::POKE_EN_HOST1));
            wire dis = acc && wr && is_cplus
                && (wd == (h == 0 ? imha_pkg::POKE_DIS_HOST0 : imha_pkg::POKE_DIS_HOST1));
            wire poke = acc && wr && is_data && (hsel == 1'(h));
            wire step = log_read && (hsel == 1'(h)) && (idx_r < BLK_END);
            wire abort = fault_log_abort_in && (ptr_r == imha_pkg::LOC_FAULT_LOG);
            wire restart = latch
                && (wd[imha_pkg::CP_PTR_HI:imha_pkg::CP_PTR_LO] == imha_pkg::LOC_FAULT_LOG);

            always_ff @(posedge sys_clk_in)
            begin
                if (rst_in)
                begin
                    ptr_r <= 9'h000;
                    page_r <= 5'h00;
                    idx_r <= '0;
                    poke_en_r <= 1'b0;
                    poke_fail_r <= 1'b0;
                    peek_fail_r <= 1'b0;
                end
                else
                begin
                    if (latch)
                    begin
                        ptr_r <= wd[imha_pkg::CP_PTR_HI:imha_pkg::CP_PTR_LO];
                        page_r <= wd[imha_pkg::CP_PAGE_HI:imha_pkg::CP_PAGE_LO];
                        idx_r <= '0;
                    end
                    else if (step)
                    begin
                        idx_r <= idx_r + 1'b1;
                    end
                    if (en)
                    begin
                        poke_en_r <= 1'b1;
                    end
                    else if (dis)
                    begin
                        poke_en_r <= 1'b0;
                    end
                    if (poke)
                    begin
                        poke_fail_r <= !poke_en_r;
                    end
                    // Abort wins over a restart in the same cycle
                    if (abort)
                    begin
                        peek_fail_r <= 1'b1;
                    end
                    else if (restart)
                    begin
                        peek_fail_r <= 1'b0;
                    end
                end
            end

            assign ptr_w[h] = ptr_r;
            assign page_w[h] = page_r;
            assign idx_w[h] = idx_r;
            assign poke_en_w[h] = poke_en_r;
            assign poke_fail_w[h] = poke_fail_r;
            assign peek_fail_w[h] = peek_fail_r;
        end
    endgenerate

    imha_blk_ram #(
        .WORDS(BLK_WORDS),
        .AW(BLK_AW)
    ) u_blk_ram (
        .sys_clk_in(sys_clk_in),
        .wr_en_in(blk_wr_in),
        .wr_addr_in(blk_waddr_in),
        .wr_data_in(blk_wdata_in),
        .rd_addr_in(sel_idx[BLK_AW-1:0]),
        .rd_data_out(ram_q)
    );

    // Sequencing of one command
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            imha_pkg::ST_IDLE:
            begin
                if (fwd_std || fwd_ind)
                begin
                    state_nxt = imha_pkg::ST_INT;
                end
                else if (log_read)
                begin
                    state_nxt = imha_pkg::ST_BUF;
                end
                else if (acc)
                begin
                    state_nxt = imha_pkg::ST_DONE;
                end
            end
            imha_pkg::ST_INT:
            begin
                if (int_ack_in)
                begin
                    state_nxt = imha_pkg::ST_DONE;
                end
            end
            imha_pkg::ST_BUF:
            begin
                state_nxt = imha_pkg::ST_DONE;
            end
            imha_pkg::ST_DONE:
            begin
                state_nxt = imha_pkg::ST_IDLE;
            end
        endcase
    end

    always_comb
    begin
        rdata_nxt = rdata_r;
        if (acc && !wr)
        begin
            rdata_nxt = own_rdata;
        end
        else if (state_r == imha_pkg::ST_INT && int_ack_in && !int_write_r)
        begin
            rdata_nxt = int_byte_in ? {8'h00, int_rdata_in[7:0]} : int_rdata_in;
        end
        else if (state_r == imha_pkg::ST_BUF)
        begin
            rdata_nxt = past_end_r ? 16'h0000 : ram_q;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            state_r <= imha_pkg::ST_IDLE;
            rdata_r <= 16'h0000;
            fault_r <= 1'b0;
            past_end_r <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            rdata_r <= rdata_nxt;
            fault_r <= acc && std_fault;
            past_end_r <= sel_idx >= BLK_END;
        end
    end

    // Indirect requests carry the host page, never the standard page
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
        begin
            int_write_r <= 1'b0;
            int_addr_r <= 9'h000;
            int_page_r <= 8'h00;
            int_global_r <= 1'b0;
            int_mask_r <= 2'h0;
            int_wdata_r <= 16'h0000;
        end
        else if (fwd_std)
        begin
            int_write_r <= wr;
            int_addr_r <= {1'b0, cmd_code_in};
            int_page_r <= cmd_page_in;
            int_global_r <= is_global;
            int_mask_r <= is_global ? mask_r : 2'h0;
            int_wdata_r <= wd;
        end
        else if (fwd_ind)
        begin
            int_write_r <= wr;
            int_addr_r <= sel_ptr;
            int_page_r <= {3'h0, sel_page};
            int_global_r <= 1'b0;
            int_mask_r <= 2'h0;
            int_wdata_r <= wd;
        end
    end

    assign bus_address_out = addr_r;
    assign global_page_channel_mask_out = mask_r;
    assign cmd_ready_out = state_r == imha_pkg::ST_IDLE;
    assign cmd_done_out = state_r == imha_pkg::ST_DONE;
    assign cmd_rdata_out = rdata_r;
    assign comm_logic_fault_out = fault_r;
    assign int_req_out = state_r == imha_pkg::ST_INT;
    assign int_write_out = int_write_r;
    assign int_addr_out = int_addr_r;
    assign int_page_out = int_page_r;
    assign int_global_out = int_global_r;
    assign int_chan_mask_out = int_mask_r;
    assign int_wdata_out = int_wdata_r;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (rst_in);

    sequence s_log_reply;
        (state_r == imha_pkg::ST_BUF) ##1 cmd_done_out;
    endsequence

    AST_ADDR_SUM: assert property (
        (asel_s2_r == 2'h3) |=> bus_address_out == 7'($past(base_r) + 7'h08))
        else $error("bus address is not base plus eight");
    AST_MASK_RD: assert property (
        (acc && !wr && is_mask) |=> cmd_done_out && cmd_rdata_out[15:2] == 14'h0000
            && cmd_rdata_out[1:0] == $past(mask_r))
        else $error("mask readback wrong");
    AST_BASE_RD: assert property (
        (acc && !wr && is_base) |=> cmd_done_out && cmd_rdata_out[15:7] == 9'h000)
        else $error("base readback upper bits not zero");
    AST_CPLUS_RD: assert property (
        (acc && !wr && is_cplus) |=> cmd_done_out && !cmd_rdata_out[15])
        else $error("indirect command bit 15 not zero");
    AST_POKE_BLOCKED: assert property (
        (acc && wr && is_data && !sel_poke_en) |=> cmd_done_out && !int_req_out
            ##0 poke_fail_w[$past(hsel)])
        else $error("poke went through while disabled");
    AST_POKE_FWD: assert property (
        (acc && wr && is_data && sel_poke_en && !sel_special) |=> int_req_out && int_write_out
            && int_addr_out == $past(sel_ptr) && int_wdata_out == $past(wd))
        else $error("enabled poke not forwarded to pointer");
    AST_GLOBAL_FAULT: assert property (
        (acc && wr && is_global && !glob_ok && !is_own && !is_hidden) |=>
            comm_logic_fault_out && cmd_done_out && !int_req_out)
        else $error("global write to unsupported command not faulted");
    AST_BYTE_ZERO: assert property (
        (int_req_out && int_ack_in && int_byte_in && !int_write_out) |=>
            cmd_done_out && cmd_rdata_out[15:8] == 8'h00)
        else $error("byte read upper byte not zero");
    AST_POKE_EN0: assert property (
        (acc && wr && is_cplus && wd == imha_pkg::POKE_EN_HOST0) |=> poke_en_w[0])
        else $error("host 0 poke enable word not honoured");
    AST_POKE_DIS1: assert property (
        (acc && wr && is_cplus && wd == imha_pkg::POKE_DIS_HOST1) |=> !poke_en_w[1])
        else $error("host 1 poke disable word not honoured");
    AST_LOG_END: assert property (
        (log_read && sel_idx >= BLK_END) |=> s_log_reply ##0 cmd_rdata_out == 16'h0000)
        else $error("read past block end not zero");
    AST_STD_PAGE: assert property (
        fwd_ind |=> int_req_out && int_page_out == {3'h0, $past(sel_page)} && !int_global_out)
        else $error("indirect access used wrong page");
endmodule // imha_top

/* verif/imha_int_model.sv */
// Behavioural model of the internal register space behind the block
`timescale 1ns/1ps
module imha_int_model (
    input wire logic clk_in,
    input wire logic req_in,
    input wire logic write_in,
    input wire logic [8:0] addr_in,
    input wire logic [7:0] page_in,
    input wire logic [15:0] wdata_in,
    input wire logic slow_in,
    output logic ack_out = 1'b0,
    output logic byte_out = 1'b0,
    output logic [15:0] rdata_out = 16'h0000,
    output logic [15:0] wlast_out = 16'h0000,
    output int wcnt_out = 0
);
    int wait_q = 0;
    always @(posedge clk_in)
    begin
        ack_out <= 1'b0;
        // Stale data must never pass for an answer
        rdata_out <= ~rdata_out;
        if (req_in && !ack_out && wait_q >= (slow_in ? 5 : 0))
        begin
            ack_out <= 1'b1;
            wait_q <= 0;
            byte_out <= addr_in[0];
            rdata_out <= {4'h0, page_in[2:0], addr_in} ^ 16'h5A00;
            if (write_in)
            begin
                wlast_out <= wdata_in ^ {addr_in, page_in[6:0]};
                wcnt_out <= wcnt_out + 1;
            end
        end
        else if (req_in)
            wait_q <= wait_q + 1;
    end
endmodule // imha_int_model

/* verif/tb_top.sv */
// Self-checking bench for the indirect multihost access block
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, rst = 1, ph = 0, pl = 0, val = 0, wr = 0, paged = 0, abort = 0, slow = 0;
    logic bwr = 0, ready, done, fault, req, iwr, ack, ibyte, glob;
    logic [7:0] code = 8'h00, page = 8'h00, ipage;
    logic [15:0] wd = 16'h0000, rd, r, iwd, ird, wlast, bd = 16'h0000;
    logic [8:0] iaddr;
    logic [6:0] badr;
    logic [1:0] bwa = 2'h0, msk, imsk;
    logic f;
    logic [15:0] buf_q [4];
    int n_fail = 0, n_checks = 0, wcnt, w0;
    logic [31:0] seed = 85;
    imha_top #(.BLK_WORDS(4), .BLK_AW(2)) imha_top_inst (.sys_clk_in(clk), .rst_in(rst),
        .addr_select_hi_pin_in(ph), .addr_select_lo_pin_in(pl), .bus_address_out(badr),
        .global_page_channel_mask_out(msk), .cmd_valid_in(val), .cmd_write_in(wr),
        .cmd_code_in(code), .cmd_page_in(page), .cmd_paged_in(paged), .cmd_wdata_in(wd),
        .cmd_ready_out(ready), .cmd_done_out(done), .cmd_rdata_out(rd),
        .comm_logic_fault_out(fault), .int_req_out(req), .int_write_out(iwr),
        .int_addr_out(iaddr), .int_page_out(ipage), .int_global_out(glob),
        .int_chan_mask_out(imsk), .int_wdata_out(iwd), .int_ack_in(ack), .int_byte_in(ibyte),
        .int_rdata_in(ird), .blk_wr_in(bwr), .blk_waddr_in(bwa), .blk_wdata_in(bd),
        .fault_log_abort_in(abort));
    imha_int_model imha_int_model_inst (.clk_in(clk), .req_in(req), .write_in(iwr),
        .addr_in(iaddr), .page_in(ipage), .wdata_in(iwd), .slow_in(slow), .ack_out(ack),
        .byte_out(ibyte), .rdata_out(ird), .wlast_out(wlast), .wcnt_out(wcnt));
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [15:0] peek_exp(input logic [8:0] a, input logic [1:0] p);
        logic [15:0] v;
        v = {4'h0, 1'b0, p, a} ^ 16'h5A00;
        return a[0] ? {8'h00, v[7:0]} : v;
    endfunction
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d);
        int k;
        @(posedge clk);
        #1;
        val = 1;
        wr = w;
        code = c;
        wd = d;
        k = 0;
        @(negedge clk);
        while (ready !== 1'b1 && k < 50)
        begin
            @(negedge clk);
            k++;
        end
        @(posedge clk);
        #1;
        val = 0;
        k = 0;
        @(negedge clk);
        while (done !== 1'b1 && k < 50)
        begin
            @(negedge clk);
            k++;
        end
        chk("done", {15'h0, done}, 16'h0001);
        r = rd;
        f = fault;
    endtask
    // Latch pointer and page for one host, then read through its data register
    task automatic peek(input logic h, input logic [1:0] p, input logic [8:0] a);
        cmd(1, 8'hC8, {1'b0, h, 3'h0, p, a});
        cmd(0, h ? 8'hCA : 8'hC9, 16'h0000);
    endtask
    task automatic summarize();
        if (n_fail == 0 && n_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        summarize();
    end
    initial
    begin
        logic [8:0] a;
        logic [1:0] p;
        logic [6:0] b;
        static logic [6:0] offs [4] = '{7'h00, 7'h01, 7'h04, 7'h08};
        logic [15:0] v;
        repeat (8) @(posedge clk);
        #1;
        rst = 0;
        for (int i = 0; i < 4; i++)
        begin
            buf_q[i] = 16'(xs());
            bwr = 1;
            bwa = i[1:0];
            bd = buf_q[i];
            @(posedge clk);
            #1;
        end
        bwr = 0;
        cmd(0, 8'hE4, 0);
        chk("mask rst", r, 16'h0003);
        cmd(0, 8'hE6, 0);
        chk("base rst", r, 16'h005C);
        cmd(1, 8'hE4, 16'h00FE);
        cmd(0, 8'hE4, 0);
        chk("mask", r, 16'h0002);
        chk("mask out", {14'h0, msk}, 16'h0002);
        b = 7'(xs());
        cmd(1, 8'hE6, {8'h00, 1'b1, b});
        cmd(0, 8'hE6, 0);
        chk("base", r, {9'h000, b});
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk);
            #1;
            {ph, pl} = i[1:0];
            repeat (5) @(posedge clk);
            #1;
            chk("bus addr", {9'h000, badr}, {9'h000, b + offs[i]});
        end
        cmd(1, 8'hC8, 16'h8000);
        cmd(0, 8'hC8, 0);
        chk("cmd bit15", r, 16'h0000);
        for (int i = 0; i < 12; i++)
        begin
            a = 9'(xs());
            a = (a == 9'h02C || a == 9'h02D || a == 9'h0EE) ? 9'h001 : a;
            p = 2'(xs());
            slow = i[0];
            peek(i[1], p, a);
            chk("peek", r, peek_exp(a, p));
        end
        w0 = wcnt;
        cmd(1, 8'hC9, 16'h1234);
        chk("poke refused", wcnt - w0, 0);
        peek(0, 0, 9'h02C);
        chk("status0", r & 16'h0002, 16'h0002);
        for (int h = 0; h < 2; h++)
        begin
            cmd(1, 8'hC8, h ? 16'h4BF6 : 16'h0BF6);
            a = 9'h021;
            p = 2'(xs());
            // Own variable: cmd overwrites the bus data signal
            v = 16'(xs());
            cmd(1, 8'hC8, {1'b0, h[0], 3'h0, p, a});
            cmd(1, h ? 8'hCA : 8'hC9, v);
            chk("poke", wlast, v ^ {a, 5'h00, p});
            cmd(1, 8'hC8, h ? 16'h41F6 : 16'h01F6);
            w0 = wcnt;
            cmd(1, h ? 8'hCA : 8'hC9, v);
            chk("poke off", wcnt - w0, 0);
        end
        peek(0, 0, 9'h0EE);
        chk("stream0", r, buf_q[0]);
        for (int i = 1; i < 6; i++)
        begin
            cmd(0, 8'hC9, 0);
            chk("stream", r, i < 4 ? buf_q[i] : 16'h0000);
        end
        peek(0, 0, 9'h0EE);
        @(posedge clk);
        #1;
        abort = 1;
        @(posedge clk);
        #1;
        abort = 0;
        peek(0, 0, 9'h02C);
        chk("abort", r & 16'h0001, 16'h0001);
        page = 8'hFF;
        paged = 1;
        cmd(0, 8'hC9, 0);
        chk("own page", {15'h0, f}, 16'h0000);
        cmd(0, 8'h20, 0);
        chk("global fault", {15'h0, f}, 16'h0001);
        w0 = wcnt;
        cmd(1, 8'h20, 16'h0055);
        chk("global drop", {15'h0, f}, 16'h0001);
        chk("global drop cnt", wcnt - w0, 0);
        cmd(1, 8'h01, 16'h0080);
        chk("global ok", {14'h0, f, glob}, 16'h0001);
        chk("global mask", {14'h0, imsk}, 16'h0002);
        chk("global cnt", wcnt - w0, 1);
        paged = 0;
        page = 8'h00;
        summarize();
    end
endmodule // tb_top
